// File: mmbh_device.sv
// Processor end of the request/grant handover, lock and queue status
// Behaviour
// - Two request/grant lines; line zero wins ties
// - Requester sends one-clock low request pulse
// - Grant pulse in T4/T1, float, then grant
// - No own bus activity while granted
// - Release pulse; reclaim bus next clock
// - Resume in T4, or T1 if idle
// - Handover is three active-low pulses
// - One idle clock between bus exchanges
// - Memory-cycle release needs all four conditions
// - Idle request: release next, or memory cycle
// - Lock low from prefix to next instruction end
// - Lock floats high during grant
// - Lock asserted in T2 of first acknowledge
// - Queue status shown the clock after operation
// - Queue status always driven
// - Queue codes 00 nop,01 first,10 empty,11 next
// - Cycle status floats high during grant
// - Functions active only in maximum mode
`timescale 1ns/10ps
`default_nettype none
module mmbh_device
	import mmbh_pkg::*;
(
	// Clock, reset, enable
	input  wire logic                clk_in,
	input  wire logic                rst_n_in,
	input  wire logic                clk_en_in,
	// Mode strap, low selects maximum mode
	input  wire logic                min_max_select_in,
	// Core bus cycle view
	input  wire mmbh_pkg::mmbh_phase_e phase_in,
	input  wire logic                mem_cycle_in,
	input  wire logic                cycle_pending_in,
	input  wire logic                odd_low_byte_in,
	input  wire logic                first_ack_in,
	input  wire logic [2:0]          core_status_in,
	// Lock and queue events from the core
	input  wire logic                lock_prefix_in,
	input  wire logic                instr_done_in,
	input  wire logic                queue_op_valid_in,
	input  wire logic [1:0]          queue_op_in,
	// Handover state for the core
	output logic                     bus_granted_out,
	output logic                     resume_t1_out,
	output logic                     resume_valid_out,
	// Link
	mmbh_if.device                   link
);
	import mmbh_pkg::*;

	mmbh_dev_e  st;
	mmbh_dev_e  next_st;
	logic       chan;
	logic       next_chan;
	logic       late_req;
	logic       next_late_req;
	logic [1:0] held_req;
	logic [1:0] next_held_req;
	logic [1:0] mode_sync;
	logic [1:0] sync_hi;
	logic [1:0] sync_lo;
	logic [1:0] echo_hi;
	logic [1:0] echo_lo;
	logic       lock_held;
	logic       next_lock_held;
	logic [1:0] qs;
	logic [1:0] next_qs;
	logic       resume_t1;
	logic       resume_valid;
	logic       next_resume_valid;
	logic       pulse;
	logic       grant_hi;
	logic       grant_lo;

	// A synchronised low is a far-side pulse unless it is the late echo
	// of our own grant pulse on the same line
	function automatic logic far_pulse(input logic max_mode_f, input logic line_sync,
		input logic own_echo);
		return max_mode_f && !line_sync && !own_echo;
	endfunction

	function automatic logic in_phase(input mmbh_phase_e now, input mmbh_phase_e want);
		return now == want;
	endfunction

	wire       max_mode = !mode_sync[1];
	wire       req_hi   = far_pulse(max_mode, sync_hi[1], echo_hi[1]);
	wire       req_lo   = far_pulse(max_mode, sync_lo[1], echo_lo[1]);
	wire [1:0] line_req = {req_lo, req_hi};
	// A pulse that lands while the other line is served is kept, not lost
	wire [1:0] any_req  = line_req | (held_req & {2{max_mode}});
	wire [1:0] pick     = {!any_req[0], any_req[0]};
	wire [1:0] serving  = {chan, !chan};
	wire       chan_req = chan ? req_lo : req_hi;
	// Early means requested no later than T2; idle requests count as early
	wire       early_ph = in_phase(phase_in, MMBH_PH_IDLE) ||
		in_phase(phase_in, MMBH_PH_T1) ||
		in_phase(phase_in, MMBH_PH_T2);
	wire       ack_t2   = max_mode && first_ack_in &&
		in_phase(phase_in, MMBH_PH_T2);
	wire       lock_n   = !(lock_held || ack_t2);
	// All four release conditions must hold in a memory cycle
	wire       mem_ok   = !late_req && !odd_low_byte_in && !first_ack_in &&
		lock_n;
	wire       idle_ok  = in_phase(phase_in, MMBH_PH_IDLE) && lock_n;
	wire       t4_ok    = mem_cycle_in && in_phase(phase_in, MMBH_PH_T4) &&
		mem_ok;
	wire       can_give = idle_ok || t4_ok;
	wire       granted  = (st == MMBH_DV_HELD);

	always_comb begin
		next_st       = st;
		next_chan     = chan;
		next_late_req = late_req;
		next_held_req = held_req | (line_req & ~serving);
		case (st)
			MMBH_DV_IDLE: begin
				next_held_req = any_req & ~pick;
				if (|any_req) begin
					next_chan     = !any_req[0];
					next_late_req = !early_ph;
					next_st       = MMBH_DV_PEND;
				end
			end
			MMBH_DV_PEND: begin
				// A late request counts as early once the next cycle begins
				if (in_phase(phase_in, MMBH_PH_T1))
					next_late_req = 1'b0;
				if (can_give)
					next_st = MMBH_DV_GRANT;
			end
			MMBH_DV_GRANT: next_st = MMBH_DV_HELD;
			MMBH_DV_HELD: begin
				if (chan_req || !max_mode)
					next_st = MMBH_DV_GAP;
			end
			MMBH_DV_GAP: next_st = MMBH_DV_IDLE;
			default: next_st = MMBH_DV_IDLE;
		endcase
	end

	// Grant pulse is the only drive the device puts on the line
	assign pulse             = (st == MMBH_DV_GRANT);
	assign grant_hi          = pulse && !chan;
	assign grant_lo          = pulse && chan;
	// Prefix set wins over completion in the same clock
	assign next_lock_held    = max_mode &&
		(lock_prefix_in || (lock_held && !instr_done_in));
	assign next_qs           = (queue_op_valid_in && max_mode) ? queue_op_in : QS_NOP;
	assign next_resume_valid = granted && (next_st == MMBH_DV_GAP);

	// No reset here: the strap settles through both flops while reset is held
	always_ff @(posedge clk_in) begin
		if (clk_en_in)
			mode_sync <= {mode_sync[0], min_max_select_in};
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			sync_hi <= SYNC_RESET;
			sync_lo <= SYNC_RESET;
			echo_hi <= 2'h0;
			echo_lo <= 2'h0;
		end else if (clk_en_in) begin
			sync_hi <= {sync_hi[0], link.bus_req_grant_high_prio};
			sync_lo <= {sync_lo[0], link.bus_req_grant_low_prio};
			// Own drive, delayed to line up with the synchronised line
			echo_hi <= {echo_hi[0], grant_hi};
			echo_lo <= {echo_lo[0], grant_lo};
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			st       <= MMBH_DV_IDLE;
			chan     <= 1'b0;
			late_req <= 1'b0;
			held_req <= 2'h0;
		end else if (clk_en_in) begin
			st       <= next_st;
			chan     <= next_chan;
			late_req <= next_late_req;
			held_req <= next_held_req;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			lock_held <= 1'b0;
			qs        <= QS_NOP;
		end else if (clk_en_in) begin
			lock_held <= next_lock_held;
			qs        <= next_qs;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			resume_t1    <= 1'b0;
			resume_valid <= 1'b0;
		end else if (clk_en_in) begin
			resume_valid <= next_resume_valid;
			resume_t1    <= !cycle_pending_in;
		end
	end

	assign link.rg_hi_out_dev   = 1'b0;
	assign link.rg_lo_out_dev   = 1'b0;
	assign link.rg_hi_oe_dev    = grant_hi;
	assign link.rg_lo_oe_dev    = grant_lo;
	assign link.lock_n_out      = lock_n;
	assign link.lock_oe         = !granted;
	assign link.cycle_status    = granted ? STATUS_PASSIVE : core_status_in;
	assign link.cycle_status_oe = !granted;
	assign link.queue_state_msb = qs[1];
	assign link.queue_state_lsb = qs[0];
	assign bus_granted_out      = granted || pulse;
	assign resume_valid_out     = resume_valid;
	assign resume_t1_out        = resume_t1;
endmodule
`default_nettype wire

// File: mmbh_pkg.sv
// Shared constants and types for the request/grant bus handover
package mmbh_pkg;
	localparam int unsigned CLK_PERIOD_NS = 10;
	// Handshake pulse is one clock wide
	localparam int unsigned PULSE_CLKS    = 1;
	// Idle-to-memory-cycle window, in clocks
	localparam int unsigned IDLE_START_CLKS = 3;
	localparam logic [1:0]  QS_NOP        = 2'h0;
	localparam logic [1:0]  QS_FIRST      = 2'h1;
	localparam logic [1:0]  QS_EMPTY      = 2'h2;
	localparam logic [1:0]  QS_NEXT       = 2'h3;
	localparam logic [2:0]  STATUS_PASSIVE = 3'h7;
	localparam logic [1:0]  SYNC_RESET    = 2'h3;

	// Bus cycle phase reported by the core
	typedef enum logic [2:0] {
		MMBH_PH_IDLE = 3'h0,
		MMBH_PH_T1   = 3'h1,
		MMBH_PH_T2   = 3'h2,
		MMBH_PH_T3   = 3'h3,
		MMBH_PH_T4   = 3'h4
	} mmbh_phase_e;

	// Device-side handover state, one machine shared by both channels
	typedef enum logic [2:0] {
		MMBH_DV_IDLE  = 3'h0,
		MMBH_DV_PEND  = 3'h1,
		MMBH_DV_GRANT = 3'h2,
		MMBH_DV_HELD  = 3'h3,
		MMBH_DV_GAP   = 3'h4
	} mmbh_dev_e;

	// Master-side handover state
	typedef enum logic [2:0] {
		MMBH_MS_IDLE = 3'h0,
		MMBH_MS_REQ  = 3'h1,
		MMBH_MS_WAIT = 3'h2,
		MMBH_MS_OWN  = 3'h3,
		MMBH_MS_REL  = 3'h4,
		MMBH_MS_GAP  = 3'h5
	} mmbh_mst_e;
endpackage

// File: mmbh_if.sv
// Interface joining the processor end and a bus master end
`timescale 1ns/10ps
`default_nettype none
interface mmbh_if;
	logic       rg_hi_out_dev;
	logic       rg_hi_oe_dev;
	logic       rg_lo_out_dev;
	logic       rg_lo_oe_dev;
	logic       rg_hi_out_mst;
	logic       rg_hi_oe_mst;
	logic       rg_lo_out_mst;
	logic       rg_lo_oe_mst;
	logic       bus_req_grant_high_prio;
	logic       bus_req_grant_low_prio;
	logic       lock_n_out;
	logic       lock_oe;
	logic [2:0] cycle_status;
	logic       cycle_status_oe;
	logic       queue_state_msb;
	logic       queue_state_lsb;

	// Open-drain style lines with internal pull-up
	assign bus_req_grant_high_prio = (rg_hi_oe_dev && !rg_hi_out_dev) ||
		(rg_hi_oe_mst && !rg_hi_out_mst) ? 1'b0 : 1'b1;
	assign bus_req_grant_low_prio = (rg_lo_oe_dev && !rg_lo_out_dev) ||
		(rg_lo_oe_mst && !rg_lo_out_mst) ? 1'b0 : 1'b1;

	modport device (
		output rg_hi_out_dev, rg_hi_oe_dev, rg_lo_out_dev, rg_lo_oe_dev,
		output lock_n_out, lock_oe, cycle_status, cycle_status_oe,
		output queue_state_msb, queue_state_lsb,
		input  bus_req_grant_high_prio, bus_req_grant_low_prio
	);
	modport master (
		output rg_hi_out_mst, rg_hi_oe_mst, rg_lo_out_mst, rg_lo_oe_mst,
		input  bus_req_grant_high_prio, bus_req_grant_low_prio,
		input  lock_n_out, lock_oe, queue_state_msb, queue_state_lsb
	);
endinterface
`default_nettype wire

// File: mmbh_master.sv
// Bus master end: requests, owns and releases the local bus
`timescale 1ns/10ps
`default_nettype none
module mmbh_master
	import mmbh_pkg::*;
(
	// Clock, reset, enable
	input  wire logic  clk_in,
	input  wire logic  rst_n_in,
	input  wire logic  clk_en_in,
	// User side
	input  wire logic  use_low_prio_in,
	input  wire logic  want_bus_in,
	input  wire logic  done_in,
	output logic       own_bus_out,
	output logic       busy_out,
	// Link
	mmbh_if.master     link
);
	import mmbh_pkg::*;

	mmbh_mst_e  st;
	mmbh_mst_e  next_st;
	logic       chan;
	logic [1:0] sync_hi;
	logic [1:0] sync_lo;
	logic [1:0] echo;

	// Our own pulse comes back through the synchroniser two clocks late
	wire line_low = (chan ? !sync_lo[1] : !sync_hi[1]) && !echo[1];
	wire drive    = (st == MMBH_MS_REQ) || (st == MMBH_MS_REL);

	always_comb begin
		next_st = st;
		case (st)
			MMBH_MS_IDLE: if (want_bus_in) next_st = MMBH_MS_REQ;
			MMBH_MS_REQ:  next_st = MMBH_MS_WAIT;
			// Only the far side's grant pulse ends the wait
			MMBH_MS_WAIT: if (line_low) next_st = MMBH_MS_OWN;
			MMBH_MS_OWN:  if (done_in) next_st = MMBH_MS_REL;
			MMBH_MS_REL:  next_st = MMBH_MS_GAP;
			MMBH_MS_GAP:  next_st = MMBH_MS_IDLE;
			default:      next_st = MMBH_MS_IDLE;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			st      <= MMBH_MS_IDLE;
			chan    <= 1'b0;
			sync_hi <= SYNC_RESET;
			sync_lo <= SYNC_RESET;
			echo    <= 2'h0;
		end else if (clk_en_in) begin
			st      <= next_st;
			echo    <= {echo[0], drive};
			sync_hi <= {sync_hi[0], link.bus_req_grant_high_prio};
			sync_lo <= {sync_lo[0], link.bus_req_grant_low_prio};
			if (st == MMBH_MS_IDLE)
				chan <= use_low_prio_in;
		end
	end

	assign link.rg_hi_out_mst = 1'b0;
	assign link.rg_lo_out_mst = 1'b0;
	assign link.rg_hi_oe_mst  = drive && !chan;
	assign link.rg_lo_oe_mst  = drive && chan;
	assign own_bus_out        = (st == MMBH_MS_OWN);
	assign busy_out           = (st != MMBH_MS_IDLE);
endmodule
`default_nettype wire

// File: mmbh_chk.sv
// Link assertions for the request/grant handover
`timescale 1ns/10ps
`default_nettype none
module mmbh_chk
	import mmbh_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	// Link signals
	input  wire logic       rg_hi_oe_dev,
	input  wire logic       rg_hi_out_dev,
	input  wire logic       rg_lo_oe_dev,
	input  wire logic       rg_hi_oe_mst,
	input  wire logic       bus_req_grant_high_prio,
	input  wire logic       bus_req_grant_low_prio,
	input  wire logic       lock_oe,
	input  wire logic [2:0] cycle_status,
	input  wire logic       cycle_status_oe
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	hi_grant_width_a: assert property (rg_hi_oe_dev |=> !rg_hi_oe_dev)
		else $error("High grant pulse too wide");
	lo_grant_width_a: assert property (rg_lo_oe_dev |=> !rg_lo_oe_dev)
		else $error("Low grant pulse too wide");
	single_grant_a: assert property (!(rg_hi_oe_dev && rg_lo_oe_dev))
		else $error("Both lines granted at once");
	grant_drives_low_a: assert property (rg_hi_oe_dev |->
		!rg_hi_out_dev && !bus_req_grant_high_prio)
		else $error("Grant pulse not low");
	grant_float_a: assert property ((rg_hi_oe_dev || rg_lo_oe_dev) |=>
		!lock_oe && !cycle_status_oe) else $error("Outputs not floated after grant");
	status_passive_a: assert property (!cycle_status_oe |-> cycle_status == STATUS_PASSIVE)
		else $error("Floated status not passive");
	req_width_a: assert property ($rose(rg_hi_oe_mst) |=> $fell(rg_hi_oe_mst))
		else $error("Master pulse too wide");
	hi_line_gap_a: assert property ($fell(bus_req_grant_high_prio) |=>
		$rose(bus_req_grant_high_prio) ##1 bus_req_grant_high_prio)
		else $error("High line pulse or gap wrong");
	lo_line_gap_a: assert property ($fell(bus_req_grant_low_prio) |=>
		$rose(bus_req_grant_low_prio) ##1 bus_req_grant_low_prio)
		else $error("Low line pulse or gap wrong");
endmodule
`default_nettype wire

// File: test_max_mode_bus_handover.sv
// Self-checking bench for both ends of the request/grant handover
`timescale 1ns/10ps
`default_nettype none
module test_max_mode_bus_handover;
	import mmbh_pkg::*;
	logic            clk_in = 1'b0, rst_n_in = 1'b0, mode_min = 1'b0, mem = 1'b0;
	logic            pend = 1'b0, odd = 1'b0, ack = 1'b0, lk_pre = 1'b0, lk_done = 1'b0;
	logic            qv = 1'b0, lo_prio = 1'b0, want = 1'b0, done = 1'b0;
	logic [1:0]      qop = 2'h0;
	mmbh_phase_e     phase = MMBH_PH_IDLE;
	logic            granted, res_t1, res_v, own, busy;
	int              errors = 0, checks = 0, cycles = 0;
	wire logic [2:0] flags;
	wire logic [1:0] qs;
	mmbh_if link();
	assign flags = {res_v, own, granted};
	assign qs = {link.queue_state_msb, link.queue_state_lsb};
	always #(CLK_PERIOD_NS / 2) clk_in = ~clk_in;
	mmbh_device i_mmbh_device (.clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1),
		.min_max_select_in(mode_min), .phase_in(phase), .mem_cycle_in(mem),
		.cycle_pending_in(pend), .odd_low_byte_in(odd), .first_ack_in(ack),
		.core_status_in(3'h5), .lock_prefix_in(lk_pre), .instr_done_in(lk_done),
		.queue_op_valid_in(qv), .queue_op_in(qop), .bus_granted_out(granted),
		.resume_t1_out(res_t1), .resume_valid_out(res_v), .link(link));
	mmbh_master i_mmbh_master (.clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1),
		.use_low_prio_in(lo_prio), .want_bus_in(want), .done_in(done), .own_bus_out(own),
		.busy_out(busy), .link(link));
	mmbh_chk i_mmbh_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.rg_hi_oe_dev(link.rg_hi_oe_dev), .rg_hi_out_dev(link.rg_hi_out_dev),
		.rg_lo_oe_dev(link.rg_lo_oe_dev), .rg_hi_oe_mst(link.rg_hi_oe_mst),
		.bus_req_grant_high_prio(link.bus_req_grant_high_prio),
		.bus_req_grant_low_prio(link.bus_req_grant_low_prio), .lock_oe(link.lock_oe),
		.cycle_status(link.cycle_status), .cycle_status_oe(link.cycle_status_oe));
	// Core phase stands idle while granted, as the core would stop its own cycles
	always @(posedge clk_in) begin
		phase <= #1 (!mem || granted) ? MMBH_PH_IDLE :
			(phase == MMBH_PH_T4) ? MMBH_PH_T1 : mmbh_phase_e'(phase + 3'h1);
		cycles++;
		if (cycles == 4000) begin
			errors++;
			final_report();
		end
	end
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic chk(input logic [2:0] got, input logic [2:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_flag(input int b);
		int i;
		i = 0;
		while (flags[b] !== 1'b1 && i < 60) begin
			step(1);
			i++;
		end
	endtask
	task automatic handover(input logic prio, input logic pnd);
		lo_prio = prio;
		pend = pnd;
		want = 1'b1;
		wait_flag(1);
		want = 1'b0;
		chk({granted, own}, 3'h3);
		chk({link.lock_oe, link.cycle_status_oe}, 3'h0);
		chk(link.cycle_status, STATUS_PASSIVE);
		done = 1'b1;
		wait_flag(2);
		done = 1'b0;
		chk(res_v, 1'b1);
		chk(res_t1, !pnd);
		step(2);
		chk({granted, own, busy}, 3'h0);
		chk(link.cycle_status, 3'h5);
	endtask
	initial begin
		step(6);
		rst_n_in = 1'b1;
		step(1);
		for (int c = 0; c < 4; c++) begin
			qv = 1'b1;
			qop = c[1:0];
			step(1);
			qv = 1'b0;
			chk(qs, c[2:0]);
			step(1);
			chk(qs, QS_NOP);
		end
		$display("Queue status test done");
		handover(1'b0, 1'b0);
		handover(1'b1, 1'b1);
		$display("Idle handover test done");
		mem = 1'b1;
		// Each pass holds off the grant with one blocking condition
		for (int b = 0; b < 3; b++) begin
			{lk_pre, ack, odd} = 3'(1 << b);
			lo_prio = b[0];
			step(1);
			lk_pre = 1'b0;
			want = 1'b1;
			repeat (24) begin
				step(1);
				chk(granted, 1'b0);
				if (ack && phase == MMBH_PH_T2) chk(link.lock_n_out, 1'b0);
				if (b == 2) chk(link.lock_n_out, 1'b0);
			end
			{ack, odd, lk_done} = {2'b0, b == 2};
			step(1);
			lk_done = 1'b0;
			if (b == 2) chk(link.lock_n_out, 1'b1);
			handover(b[0], 1'b1);
		end
		$display("Memory cycle test done");
		mem = 1'b0;
		mode_min = 1'b1;
		want = 1'b1;
		step(30);
		chk({granted, own, busy}, 3'h1);
		$display("Mode select test done");
		final_report();
	end
endmodule
`default_nettype wire
